// ---- verilog/ccp_compare_pwm.sv ----
// compare and pwm unit with its register file on an avalon-mm slave
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ccp_regs.svh"

module ccp_compare_pwm
(
	input wire logic clk,
	input wire logic rst,
	input ccp_pkg::bus_req_t bus_req,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [15:0] timer1_count,
	input wire logic timer1_overflow,
	output logic [7:0] timer1_control,
	output logic timer1_reset,
	output logic adc_start,
	output logic unit_output_pin_out,
	output logic unit_output_pin_oe
);
	import ccp_pkg::*;

	logic [7:0] core_interrupt_control;
	logic [7:0] peripheral_interrupt_flags;
	logic [7:0] peripheral_interrupt_enables;
	logic [7:0] port_c_direction;
	logic [7:0] timer2_control;
	logic [7:0] timer2_period_value;
	logic [7:0] compare_value_low;
	logic [7:0] compare_value_high;
	logic [7:0] unit_mode_control;
	logic [1:0] duty_lsb_active;
	logic match_q;
	logic [31:0] next_readdata;
	logic [7:0] index;
	logic [7:0] wdata;
	logic write_taken;
	logic mode_zero_write;
	logic compare_equal;
	logic compare_event;
	logic is_compare;
	logic is_pwm;
	logic [9:0] next_duty;
	logic [9:0] active_duty;
	logic [9:0] position;
	logic [7:0] flag_sets;
	unit_mode_t mode;
	time_base_t tb;

	function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
		return idx == reg_idx;
	endfunction : hit

	assign index = bus_req.address[9:2];
	assign wdata = bus_req.writedata[7:0];
	assign write_taken = bus_req.write && !waitrequest && bus_req.byteenable[0];
	assign mode_zero_write = write_taken && hit(index, `IDX_MODE_CTRL) && (wdata == 8'h00);

	assign mode = decode_mode(unit_mode_control[3:0]);
	assign is_pwm = (mode == MODE_PWM);
	assign is_compare = (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLEAR) ||
		(mode == MODE_CMP_SOFT) || (mode == MODE_CMP_TRIGGER);

	// duty from low byte and lsb bits
	assign next_duty = {compare_value_low, unit_mode_control[`POS_DUTY_LSB +: 2]};
	// active copy in high byte plus latch
	assign active_duty = {compare_value_high, duty_lsb_active};
	assign position = {tb.count, tb.ext};

	timer2_base u_timer2
	(
		.clk(clk),
		.rst(rst),
		.enable(timer2_control[`BIT_TIMER2_ON]),
		.presc_sel(timer2_control[1:0]),
		.postscale(timer2_control[`POS_POSTSCALE +: 4]),
		.period(timer2_period_value),
		.count_write(write_taken && hit(index, `IDX_TIMER2_COUNT)),
		.write_data(wdata),
		.tb(tb)
	);

	// bus slave: one wait cycle, then the request is taken
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((bus_req.read || bus_req.write) && waitrequest);
	end

	always_comb
	begin
		next_readdata = 32'h00000000;
		case (index)
			`IDX_CORE_INT_CTRL: next_readdata[7:0] = core_interrupt_control;
			`IDX_PERIPH_FLAGS: next_readdata[7:0] = peripheral_interrupt_flags;
			`IDX_TIMER1_LOW: next_readdata[7:0] = timer1_count[7:0];
			`IDX_TIMER1_HIGH: next_readdata[7:0] = timer1_count[15:8];
			`IDX_TIMER1_CTRL: next_readdata[7:0] = timer1_control;
			`IDX_TIMER2_COUNT: next_readdata[7:0] = tb.count;
			`IDX_TIMER2_CTRL: next_readdata[7:0] = timer2_control;
			`IDX_CMP_LOW: next_readdata[7:0] = compare_value_low;
			`IDX_CMP_HIGH: next_readdata[7:0] = compare_value_high;
			`IDX_MODE_CTRL: next_readdata[7:0] = unit_mode_control;
			`IDX_PORT_C_DIR: next_readdata[7:0] = port_c_direction;
			`IDX_PERIPH_ENABLES: next_readdata[7:0] = peripheral_interrupt_enables;
			`IDX_TIMER2_PERIOD: next_readdata[7:0] = timer2_period_value;
			default: next_readdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			readdata <= 32'h00000000;
		else if (bus_req.read && waitrequest)
			readdata <= next_readdata;
	end

	// plain storage registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			core_interrupt_control <= `RST_CORE_INT_CTRL;
			peripheral_interrupt_enables <= `RST_PERIPH_ENABLES;
			port_c_direction <= `RST_PORT_C_DIR;
			timer1_control <= `RST_TIMER1_CTRL;
			timer2_control <= `RST_TIMER2_CTRL;
			timer2_period_value <= `RST_TIMER2_PERIOD;
			compare_value_low <= `RST_CMP_VALUE;
			unit_mode_control <= `RST_MODE_CTRL;
		end
		else if (write_taken)
		begin
			case (index)
				`IDX_CORE_INT_CTRL: core_interrupt_control <= wdata;
				`IDX_PERIPH_ENABLES: peripheral_interrupt_enables <= wdata & `MASK_PERIPH;
				`IDX_PORT_C_DIR: port_c_direction <= wdata & `MASK_PORT_C_DIR;
				`IDX_TIMER1_CTRL: timer1_control <= wdata & `MASK_TIMER1_CTRL;
				`IDX_TIMER2_CTRL: timer2_control <= wdata & `MASK_TIMER2_CTRL;
				`IDX_TIMER2_PERIOD: timer2_period_value <= wdata;
				`IDX_CMP_LOW: compare_value_low <= wdata;
				`IDX_MODE_CTRL: unit_mode_control <= wdata & `MASK_MODE_CTRL;
				default: core_interrupt_control <= core_interrupt_control;
			endcase
		end
	end

	// duty copied into active latch at period end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			compare_value_high <= `RST_CMP_VALUE;
			duty_lsb_active <= 2'b00;
		end
		else if (is_pwm && tb.period_end)
		begin
			compare_value_high <= compare_value_low;
			duty_lsb_active <= unit_mode_control[`POS_DUTY_LSB +: 2];
		end
		else if (write_taken && hit(index, `IDX_CMP_HIGH) && !is_pwm)
			compare_value_high <= wdata;
	end

	// equality against timer1; count assumed synchronous
	assign compare_equal = (timer1_count == {compare_value_high, compare_value_low});
	// one event per match, not per cycle the count stays equal
	assign compare_event = is_compare && compare_equal && !match_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			match_q <= 1'b0;
		else
			match_q <= compare_equal;
	end

	// unit flag set with the pin action
	// timer1 flag only from real overflow
	always_comb
	begin
		flag_sets = 8'h00;
		flag_sets[`BIT_UNIT_FLAG] = compare_event;
		flag_sets[`BIT_TIMER2_FLAG] = tb.post_pulse;
		flag_sets[`BIT_TIMER1_FLAG] = timer1_overflow;
	end

	// a hardware set in the cycle of a software clear still wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			peripheral_interrupt_flags <= `RST_PERIPH_FLAGS;
		else if (write_taken && hit(index, `IDX_PERIPH_FLAGS))
			peripheral_interrupt_flags <= (wdata & `MASK_PERIPH) | flag_sets;
		else
			peripheral_interrupt_flags <= peripheral_interrupt_flags | flag_sets;
	end

	// trigger resets timer1 and starts conversion
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timer1_reset <= 1'b0;
			adc_start <= 1'b0;
		end
		else
		begin
			timer1_reset <= compare_event && (mode == MODE_CMP_TRIGGER);
			adc_start <= compare_event && (mode == MODE_CMP_TRIGGER);
		end
	end

	// output latch; the port data latch lives outside and is never touched
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			unit_output_pin_out <= 1'b0;
		// zero control write forces latch low
		else if (mode_zero_write)
			unit_output_pin_out <= 1'b0;
		else if (is_pwm)
		begin
			// set beats clear, so duty beyond period stays high
			if (tb.period_end)
				unit_output_pin_out <= (next_duty != 10'h000);
			// clear as position steps onto the duty
			else if (tb.step && (position + 10'h001 == active_duty))
				unit_output_pin_out <= 1'b0;
		end
		// soft mode falls through and leaves the pin alone
		else if (compare_event && (mode == MODE_CMP_SET))
			unit_output_pin_out <= 1'b1;
		else if (compare_event && (mode == MODE_CMP_CLEAR))
			unit_output_pin_out <= 1'b0;
	end

	// pin drives only when direction bit is clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			unit_output_pin_oe <= 1'b0;
		else
			unit_output_pin_oe <= !port_c_direction[`BIT_PIN_DIR] && (is_pwm || is_compare);
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// compare side
	a_cmp_flag_set : assert property (compare_event |=> peripheral_interrupt_flags[`BIT_UNIT_FLAG])
		else $error("unit flag not set after compare match");
	a_flag_sticky : assert property (peripheral_interrupt_flags[`BIT_UNIT_FLAG]
		&& !(write_taken && hit(index, `IDX_PERIPH_FLAGS)) |=> peripheral_interrupt_flags[`BIT_UNIT_FLAG])
		else $error("unit flag lost without a software clear");
	a_cmp_pin_high : assert property (compare_event && mode == MODE_CMP_SET && !mode_zero_write
		|=> unit_output_pin_out)
		else $error("pin not driven high on match");
	a_cmp_pin_low : assert property (compare_event && mode == MODE_CMP_CLEAR |=> !unit_output_pin_out)
		else $error("pin not driven low on match");
	a_off_no_drive : assert property (mode == MODE_OFF |=> !unit_output_pin_oe)
		else $error("pin driven with the unit off");
	a_one_event : assert property (compare_event |=> !compare_event)
		else $error("one match gave two events");
	a_soft_pin_hold : assert property (mode == MODE_CMP_SOFT && !write_taken
		|=> $stable(unit_output_pin_out))
		else $error("soft interrupt mode changed the pin");
	a_trig_pulses : assert property (compare_event && mode == MODE_CMP_TRIGGER
		|=> timer1_reset && adc_start ##1 !timer1_reset)
		else $error("special event trigger pulse wrong");
	a_trig_pair : assert property (timer1_reset == adc_start)
		else $error("timer1 reset and conversion start apart");
	a_no_t1_flag : assert property (!peripheral_interrupt_flags[`BIT_TIMER1_FLAG] && !timer1_overflow
		&& !(write_taken && hit(index, `IDX_PERIPH_FLAGS)) |=> !peripheral_interrupt_flags[`BIT_TIMER1_FLAG])
		else $error("timer1 flag set without overflow");
	a_zero_write_low : assert property (mode_zero_write |=> !unit_output_pin_out)
		else $error("zero control write left latch high");
	a_oe_released : assert property (port_c_direction[`BIT_PIN_DIR] |=> !unit_output_pin_oe)
		else $error("pin driven while direction is input");

	// pwm side
	a_duty_latched : assert property (is_pwm && tb.period_end
		|=> compare_value_high == $past(compare_value_low))
		else $error("duty not latched at period end");
	a_lsb_latched : assert property (is_pwm && tb.period_end
		|=> duty_lsb_active == $past(unit_mode_control[`POS_DUTY_LSB +: 2]))
		else $error("duty low bits not latched at period end");
	a_high_read_only : assert property (is_pwm && !tb.period_end && write_taken
		&& hit(index, `IDX_CMP_HIGH) |=> $stable(compare_value_high))
		else $error("high byte written in pwm mode");
	a_zero_duty_low : assert property (is_pwm && tb.period_end && next_duty == 10'h000 && !mode_zero_write
		|=> !unit_output_pin_out)
		else $error("pin set with zero duty");
	a_pwm_set : assert property (is_pwm && tb.period_end && next_duty != 10'h000 && !mode_zero_write
		|=> unit_output_pin_out)
		else $error("pin not set at period start");
	a_pin_clear_duty : assert property (is_pwm && !tb.period_end && tb.step && !mode_zero_write
		&& (position + 10'h001 == active_duty) |=> !unit_output_pin_out)
		else $error("pin not cleared at duty match");
	a_t2_clear : assert property (tb.period_end && !(write_taken && hit(index, `IDX_TIMER2_COUNT))
		|=> tb.count == 8'h00)
		else $error("timer2 not cleared at period match");

	// bus side
	a_bus_answer : assert property ((bus_req.read || bus_req.write) && waitrequest
		|=> !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");
	a_idle_wait : assert property (!(bus_req.read || bus_req.write) |=> waitrequest)
		else $error("wait request low with no request");
	a_readdata_hold : assert property (!(bus_req.read && waitrequest) |=> $stable(readdata))
		else $error("read data moved without a read");
	a_upper_zero : assert property (readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");

	c_compare_match : cover property (compare_event && mode == MODE_CMP_SET);
	c_soft_match : cover property (compare_event && mode == MODE_CMP_SOFT);
	c_pwm_period : cover property (is_pwm && tb.period_end && next_duty != 10'h000);
	c_zero_duty : cover property (is_pwm && tb.period_end && next_duty == 10'h000);
	c_trigger : cover property (timer1_reset);

endmodule : ccp_compare_pwm

// ---- verilog/ccp_regs.svh ----
// register indices, field positions and reset values of the compare/pwm unit
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH

`define IDX_CORE_INT_CTRL 8'h0b
`define IDX_PERIPH_FLAGS 8'h0c
`define IDX_TIMER1_LOW 8'h0e
`define IDX_TIMER1_HIGH 8'h0f
`define IDX_TIMER1_CTRL 8'h10
`define IDX_TIMER2_COUNT 8'h11
`define IDX_TIMER2_CTRL 8'h12
`define IDX_CMP_LOW 8'h15
`define IDX_CMP_HIGH 8'h16
`define IDX_MODE_CTRL 8'h17
`define IDX_PORT_C_DIR 8'h87
`define IDX_PERIPH_ENABLES 8'h8c
`define IDX_TIMER2_PERIOD 8'h92

`define RST_CORE_INT_CTRL 8'h00
`define RST_PERIPH_FLAGS 8'h00
`define RST_TIMER1_CTRL 8'h00
`define RST_TIMER2_CTRL 8'h00
`define RST_TIMER2_COUNT 8'h00
`define RST_CMP_VALUE 8'h00
`define RST_MODE_CTRL 8'h00
`define RST_PORT_C_DIR 8'h3f
`define RST_PERIPH_ENABLES 8'h00
`define RST_TIMER2_PERIOD 8'hff

`define MASK_MODE_CTRL 8'h3f
`define MASK_PERIPH 8'hcf
`define MASK_TIMER1_CTRL 8'h3f
`define MASK_TIMER2_CTRL 8'h7f
`define MASK_PORT_C_DIR 8'h3f

`define BIT_UNIT_FLAG 2
`define BIT_TIMER2_FLAG 1
`define BIT_TIMER1_FLAG 0
`define BIT_PIN_DIR 2
`define BIT_TIMER2_ON 2
`define POS_DUTY_LSB 4
`define POS_POSTSCALE 3

`endif

// ---- verilog/ccp_pkg.sv ----
// types shared by the compare/pwm unit and its time base
package ccp_pkg;

	typedef enum logic [2:0]
	{
		MODE_OFF = 3'b000,
		MODE_CMP_SET = 3'b001,
		MODE_CMP_CLEAR = 3'b010,
		MODE_CMP_SOFT = 3'b011,
		MODE_CMP_TRIGGER = 3'b100,
		MODE_PWM = 3'b101,
		MODE_OTHER = 3'b110
	} unit_mode_t;

	typedef struct packed
	{
		logic read;
		logic write;
		logic [9:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} bus_req_t;

	typedef struct packed
	{
		logic [7:0] count;
		logic [1:0] ext;
		logic step;
		logic period_end;
		logic post_pulse;
	} time_base_t;

	function automatic unit_mode_t decode_mode(input logic [3:0] field);
		unit_mode_t m;
		m = MODE_OTHER;
		case (field)
			4'h0: m = MODE_OFF;
			4'h8: m = MODE_CMP_SET;
			4'h9: m = MODE_CMP_CLEAR;
			4'ha: m = MODE_CMP_SOFT;
			4'hb: m = MODE_CMP_TRIGGER;
			4'hc, 4'hd, 4'he, 4'hf: m = MODE_PWM;
			default: m = MODE_OTHER;
		endcase
		return m;
	endfunction : decode_mode

endpackage : ccp_pkg

// ---- verilog/timer2_base.sv ----
// timer2 time base for pwm: prescaler, count, period match and postscaler
`timescale 1ns/1ps
`include "ccp_regs.svh"

module timer2_base
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [1:0] presc_sel,
	input wire logic [3:0] postscale,
	input wire logic [7:0] period,
	input wire logic count_write,
	input wire logic [7:0] write_data,
	output ccp_pkg::time_base_t tb
);
	import ccp_pkg::*;

	logic [5:0] pre_cnt;
	logic [5:0] pre_max;
	logic [7:0] count;
	logic [3:0] post_cnt;
	logic tick;
	logic step;
	logic [1:0] ext;
	logic period_end;

	// prescale 1/4/16, four oscillator clocks per increment
	always_comb
	begin
		case (presc_sel)
			2'b00:
			begin
				pre_max = 6'h03;
				ext = pre_cnt[1:0];
				step = 1'b1;
			end
			2'b01:
			begin
				pre_max = 6'h0f;
				ext = pre_cnt[3:2];
				step = (pre_cnt[1:0] == 2'h3);
			end
			default:
			begin
				pre_max = 6'h3f;
				ext = pre_cnt[5:4];
				step = (pre_cnt[3:0] == 4'hf);
			end
		endcase
	end

	assign tick = enable && (pre_cnt == pre_max);
	assign period_end = tick && (count == period);

	// a count write also restarts the prescaler so the first step is full length
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pre_cnt <= 6'h00;
		else if (count_write || !enable || tick)
			pre_cnt <= 6'h00;
		else
			pre_cnt <= pre_cnt + 6'h01;
	end

	// match with period clears the count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count <= `RST_TIMER2_COUNT;
		else if (count_write)
			count <= write_data;
		else if (period_end)
			count <= 8'h00;
		else if (tick)
			count <= count + 8'h01;
	end

	// postscaler only paces the timer2 flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			post_cnt <= 4'h0;
		else if (period_end)
			post_cnt <= (post_cnt == postscale) ? 4'h0 : post_cnt + 4'h1;
	end

	// two low bits come from the quarter phase or prescaler
	always_comb
	begin
		tb.count = count;
		tb.ext = ext;
		tb.step = enable && step;
		tb.period_end = period_end;
		tb.post_pulse = period_end && (post_cnt == postscale);
	end

endmodule : timer2_base

// ---- verif/pin_load.sv ----
// load on the unit pin, measuring pulse high time and period
`timescale 1ns/1ps

module pin_load
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic [15:0] high_len,
	output logic [15:0] period_len,
	output logic [15:0] pulses,
	output logic [15:0] rises
);
	logic level;
	logic last;
	logic [15:0] hcnt;
	logic [15:0] pcnt;
	// pin seen only when driven
	// a released pin is pulled down by the load, so a missing enable shows as low
	assign level = pin_oe ? pin_out : 1'b0;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{last, hcnt, pcnt, high_len, period_len, pulses, rises} <= '0;
		end
		else
		begin
			last <= level;
			hcnt <= level ? hcnt + 16'h1 : 16'h0;
			pcnt <= (level && !last) ? 16'h1 : pcnt + 16'h1;
			if (level && !last)
			begin
				rises <= rises + 16'h1;
				period_len <= pcnt;
			end
			if (!level && last)
			begin
				pulses <= pulses + 16'h1;
				high_len <= hcnt;
			end
		end
	end
endmodule : pin_load

// ---- verif/ccp_compare_pwm_test.sv ----
// self-checking bench for the compare/pwm unit
`timescale 1ns/1ps

module ccp_compare_pwm_test;
	import ccp_pkg::*;
	logic clk;
	logic rst;
	bus_req_t bus_req;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] timer1_count;
	logic timer1_overflow;
	logic [7:0] timer1_control;
	logic timer1_reset;
	logic adc_start;
	logic pin_out;
	logic pin_oe;
	logic [15:0] high_len, period_len, pulses, rises, r0;
	logic [31:0] rd;
	int miscompares;
	int checks;
	int cycles;
	logic [7:0] ridx [12] = '{8'h0b, 8'h0c, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h87, 8'h8c, 8'h92, 8'h20};
	logic [7:0] rval [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'hff, 8'h00};
	logic [7:0] cmode [5] = '{8'h08, 8'h0a, 8'h09, 8'h0b, 8'h08};
	logic cpin [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic ctrig [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int ps [3] = '{1, 4, 16};
	logic [7:0] pp [3] = '{8'h07, 8'h07, 8'h03};
	logic [9:0] dd [3] = '{10'h00d, 10'h00d, 10'h009};

	ccp_compare_pwm u_dut
	(
		.clk(clk),
		.rst(rst),
		.bus_req(bus_req),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.timer1_count(timer1_count),
		.timer1_overflow(timer1_overflow),
		.timer1_control(timer1_control),
		.timer1_reset(timer1_reset),
		.adc_start(adc_start),
		.unit_output_pin_out(pin_out),
		.unit_output_pin_oe(pin_oe)
	);

	pin_load u_load
	(
		.clk(clk),
		.rst(rst),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.high_len(high_len),
		.period_len(period_len),
		.pulses(pulses),
		.rises(rises)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the longest test is a few thousand cycles, so this only trips on a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	task give_verdict;
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// values read after an edge show the state left by the previous edge
	task access(input logic is_wr, input logic [7:0] idx, input logic [7:0] d);
		bus_req <= '{read: !is_wr, write: is_wr, address: {idx, 2'b00}, writedata: {24'h0, d}, byteenable: 4'h1};
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		bus_req <= '0;
		@(posedge clk);
	endtask : access

	task wr(input logic [7:0] idx, input logic [7:0] d);
		access(1'b1, idx, d);
	endtask : wr

	task rdchk(input logic [7:0] idx, input logic [7:0] exp);
		access(1'b0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask : rdchk

	task cmp_event(input logic [7:0] mode, input logic pin, input logic trig);
		wr(8'h17, mode);
		timer1_count <= 16'h1234;
		@(posedge clk);
		@(posedge clk);
		check(32'(pin_out), 32'(pin));
		check(32'({timer1_reset, adc_start}), trig ? 32'h3 : 32'h0);
		@(posedge clk);
		check(32'(timer1_reset), 32'h0);
		timer1_count <= 16'h0000;
		rdchk(8'h0c, 8'h04);
		wr(8'h0c, 8'h00);
	endtask : cmp_event

	task pwm_cfg(input logic [7:0] per, input logic [1:0] sel, input logic [9:0] duty);
		wr(8'h17, 8'h00);
		@(posedge clk);
		check(32'(pin_out), 32'h0);
		wr(8'h92, per);
		wr(8'h15, duty[9:2]);
		wr(8'h17, {2'b00, duty[1:0], 4'h0});
		wr(8'h12, {1'b0, 4'hf, 1'b1, sel});
		wr(8'h11, 8'h00);
		wr(8'h17, {2'b00, duty[1:0], 4'hc});
	endtask : pwm_cfg

	task pwm_meas(input int per, input int high);
		int n;
		n = pulses + 3;
		while (pulses < n) @(posedge clk);
		check(32'(period_len), 32'(per));
		check(32'(high_len), 32'(high));
	endtask : pwm_meas

	task steady(input logic [9:0] duty, input logic lvl);
		pwm_cfg(8'h03, 2'b00, duty);
		repeat (40) @(posedge clk);
		r0 = rises;
		repeat (64) @(posedge clk);
		check(32'(rises), 32'(r0));
		check(32'(pin_out), 32'(lvl));
	endtask : steady

	initial
	begin
		rst = 1'b1;
		bus_req = '0;
		timer1_count = 16'h0000;
		timer1_overflow = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(32'({pin_oe, pin_out}), 32'h0);
		for (int i = 0; i < 12; i++) rdchk(ridx[i], rval[i]);
		wr(8'h10, 8'hff);
		rdchk(8'h10, 8'h3f);
		check(32'(timer1_control), 32'h3f);
		timer1_count <= 16'h5a77;
		wr(8'h0e, 8'h00);
		rdchk(8'h0e, 8'h77);
		rdchk(8'h0f, 8'h5a);
		timer1_overflow <= 1'b1;
		@(posedge clk);
		timer1_overflow <= 1'b0;
		rdchk(8'h0c, 8'h01);
		wr(8'h0c, 8'h00);
		wr(8'h15, 8'h34);
		wr(8'h16, 8'h12);
		wr(8'h17, 8'h08);
		check(32'(pin_oe), 32'h0);
		wr(8'h87, 8'h3b);
		// the enable follows the direction bit one edge later
		@(posedge clk);
		check(32'(pin_oe), 32'h1);
		for (int i = 0; i < 5; i++) cmp_event(cmode[i], cpin[i], ctrig[i]);
		wr(8'h17, 8'h00);
		@(posedge clk);
		check(32'(pin_out), 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			pwm_cfg(pp[i], 2'(i), dd[i]);
			pwm_meas((pp[i] + 1) * 4 * ps[i], dd[i] * ps[i]);
		end
		pwm_cfg(8'h07, 2'b00, 10'h00d);
		pwm_meas(32, 13);
		r0 = rises;
		while (rises == r0) @(posedge clk);
		wr(8'h15, 8'h05);
		wr(8'h17, 8'h0c);
		wr(8'h16, 8'hff);
		rdchk(8'h16, 8'h03);
		pwm_meas(32, 20);
		rdchk(8'h16, 8'h05);
		steady(10'h3ff, 1'b1);
		steady(10'h000, 1'b0);
		give_verdict();
	end
endmodule : ccp_compare_pwm_test
